// ### pkg/uir_defines.svh
// constants for the indirect usb register port
`ifndef UIR_DEFINES_SVH
`define UIR_DEFINES_SVH

// special function register addresses of the two port registers
`define UIR_SFR_CTRL 8'h96
`define UIR_SFR_DATA 8'h97
// address/control register fields and reset values
`define UIR_BUSY_BIT 7
`define UIR_AUTO_BIT 6
`define UIR_ADDR_MSB 5
`define UIR_RESET_CTRL 8'h00
`define UIR_RESET_DATA 8'h00
`define UIR_RESET_ENDPOINT_SELECT_FIELD 4'h0
// indirect map
`define UIR_IX_FUNC_ADDR 6'h00
`define UIR_IX_POWER 6'h01
`define UIR_IX_IN_IRQ 6'h02
`define UIR_IX_OUT_IRQ 6'h04
`define UIR_IX_CMN_IRQ 6'h06
`define UIR_IX_IN_IE 6'h07
`define UIR_IX_OUT_IE 6'h09
`define UIR_IX_CMN_IE 6'h0B
`define UIR_IX_FRAME_LO 6'h0C
`define UIR_IX_FRAME_HI 6'h0D
`define UIR_IX_INDEX 6'h0E
`define UIR_IX_CLK_REC 6'h0F
`define UIR_IX_EP0_CSR 6'h11
`define UIR_IX_IN_CSR_HI 6'h12
`define UIR_IX_OUT_CSR_LO 6'h14
`define UIR_IX_OUT_CSR_HI 6'h15
`define UIR_IX_EP0_CNT 6'h16
`define UIR_IX_OUT_CNT_HI 6'h17
`define UIR_IX_EP_ENABLE 6'h1E
`define UIR_IX_FIFO_BASE 4'h8
// number of endpoints the index field may select
`define UIR_EP_COUNT 4'h4
// timing of one access inside the usb controller
`define UIR_CLK_NS 50
`define UIR_ACCESS_NS 200
`define UIR_ACCESS_CYC ((`UIR_ACCESS_NS + `UIR_CLK_NS - 1) / `UIR_CLK_NS)

`endif

// ### pkg/uir_pkg.sv
// types for the indirect usb register port
package uir_pkg;

	typedef enum logic [1:0] {
		UIR_IDLE = 2'b00,
		UIR_ACC = 2'b01,
		UIR_CAPT = 2'b10
	} uir_state_t;

	typedef enum logic [2:0] {
		UIR_K_NONE = 3'b000,
		UIR_K_MEM = 3'b001,
		UIR_K_FRAME_LO = 3'b010,
		UIR_K_FRAME_HI = 3'b011,
		UIR_K_INDEX = 3'b100,
		UIR_K_FIFO = 3'b101
	} uir_kind_t;

	typedef struct packed {
		uir_kind_t kind;
		logic [6:0] slot;
	} uir_dec_t;

endpackage

// ### pkg/uir_mem_if.sv
// carrier between the port controller and the register store
`timescale 1ns/1ps
interface uir_mem_if #(
	parameter int AW = 7,
	parameter int DW = 8
);
	logic we;
	logic re;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl (output we, output re, output addr, output wdata, input rdata);
	modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// ### src/uir_regmem.sv
// backing store of the usb controller registers reached indirectly
`timescale 1ns/1ps
module uir_regmem (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	uir_mem_if.mem m
);
	logic [m.DW-1:0] store [2**m.AW];

	// array is not reset so that it can map onto a ram macro
	always_ff @(posedge i_clk) begin
		if (m.we) begin
			store[m.addr] <= m.wdata;
		end
	end

	// read data leaves through a register, one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			m.rdata <= '0;
		end else if (m.re) begin
			m.rdata <= store[m.addr];
		end
	end
endmodule

// ### src/uir_port.sv
// indirect port from the core special function registers into the usb controller register space
//
// Function
// - busy bit 7 reads 1 while an access runs, 0 once data is valid
// - writing busy 1 starts a read; address and busy may share one write
// - auto-read flag bit 6: each data register read while idle starts next read, address kept
// - without auto-read, reads start only when software writes busy
// - six-bit target address in bits 5:0 selects the usb register
// - data register writes go to target, reads return last fetched byte
// - interrupt flags decoded at 0x02, 0x04 and 0x06
// - interrupt enables decoded at 0x07, 0x09 and 0x0B
// - frame number at 0x0C/0x0D, index at 0x0E, plus other common registers
// - 0x11 is endpoint 0 or in control low by index; 0x12 in high
// - out control/status low and high at 0x14 and 0x15 per endpoint
// - 0x16 endpoint 0 count or out count low; 0x17 out count high
// - index register endpoint field selects endpoints 0 to 3; higher reserved
`timescale 1ns/1ps
`include "uir_defines.svh"
module uir_port import uir_pkg::*; #(
	parameter int ACCESS_CYC = `UIR_ACCESS_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	input wire logic [10:0] i_frame_num,
	output logic o_fifo_rd_stb,
	output logic o_fifo_wr_stb,
	output logic [1:0] o_fifo_ep,
	output logic [7:0] o_fifo_wdata,
	input wire logic [7:0] i_fifo_rdata
);
	// a read needs one more cycle than a write, to move the stored byte into the data register
	localparam int RD_LAT = ACCESS_CYC + 1;

	// the counter is eight bits wide
	if (ACCESS_CYC < 1 || ACCESS_CYC > 255) begin : g_bad_access
		$error("uir_port: ACCESS_CYC must lie in 1..255");
	end

	// the store has registered read data, which is why a read passes through a capture state
	uir_mem_if #(.AW(7), .DW(8)) m ();

	uir_regmem u_mem (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.m(m)
	);

	uir_state_t st_r;
	logic [7:0] cnt_r;
	logic auto_r;
	logic [5:0] taddr_r;
	logic [7:0] data_r;
	logic [7:0] wbyte_r;
	logic [3:0] endpoint_select_field_r;
	logic op_wr_r;
	logic [5:0] op_addr_r;
	uir_dec_t dec_r;
	uir_dec_t dec_nxt;
	logic [5:0] op_addr_nxt;
	logic busy_w;
	logic idle_w;
	logic wr_ctrl;
	logic wr_data;
	logic rd_ctrl;
	logic rd_data;
	logic start_rd;
	logic start_wr;
	logic issue_w;

	// decode of the six-bit indirect address under the current endpoint select
	function automatic uir_dec_t decode(input logic [5:0] a, input logic [3:0] ep);
		uir_dec_t d;
		d.kind = UIR_K_NONE;
		d.slot = 7'h00;
		case (a)
			`UIR_IX_FUNC_ADDR, `UIR_IX_POWER, `UIR_IX_CLK_REC, `UIR_IX_EP_ENABLE,
			`UIR_IX_IN_IRQ, `UIR_IX_OUT_IRQ, `UIR_IX_CMN_IRQ,
			`UIR_IX_IN_IE, `UIR_IX_OUT_IE, `UIR_IX_CMN_IE: begin
				d.kind = UIR_K_MEM;
				d.slot = {1'b0, a};
			end
			`UIR_IX_FRAME_LO: d.kind = UIR_K_FRAME_LO;
			`UIR_IX_FRAME_HI: d.kind = UIR_K_FRAME_HI;
			`UIR_IX_INDEX: d.kind = UIR_K_INDEX;
			// indexed registers live in one bank per endpoint
			`UIR_IX_EP0_CSR, `UIR_IX_IN_CSR_HI, `UIR_IX_OUT_CSR_LO,
			`UIR_IX_OUT_CSR_HI, `UIR_IX_EP0_CNT, `UIR_IX_OUT_CNT_HI: begin
				if (ep < `UIR_EP_COUNT) begin // reserved selects reach nothing
					d.kind = UIR_K_MEM;
					d.slot = {1'b1, ep[1:0], a[3:0]};
				end
			end
			default: begin
				if (a[5:2] == `UIR_IX_FIFO_BASE) begin
					d.kind = UIR_K_FIFO;
					d.slot = {5'h00, a[1:0]};
				end
			end
		endcase
		return d;
	endfunction

	// strobes from the sfr bus
	assign wr_ctrl = i_sfr_wr && (i_sfr_addr == `UIR_SFR_CTRL);
	assign wr_data = i_sfr_wr && (i_sfr_addr == `UIR_SFR_DATA);
	assign rd_ctrl = i_sfr_rd && (i_sfr_addr == `UIR_SFR_CTRL);
	assign rd_data = i_sfr_rd && (i_sfr_addr == `UIR_SFR_DATA);
	assign idle_w = (st_r == UIR_IDLE);
	assign busy_w = !idle_w;

	// a read starts only by a busy write or by auto-read
	assign start_rd = idle_w && ((wr_ctrl && i_sfr_wdata[`UIR_BUSY_BIT]) || (rd_data && auto_r));
	// software is expected to poll busy first; a write while busy is dropped
	assign start_wr = idle_w && wr_data;
	// address from the same write that sets busy is used at once
	assign op_addr_nxt = wr_ctrl ? i_sfr_wdata[`UIR_ADDR_MSB:0] : taddr_r;
	assign dec_nxt = decode(op_addr_nxt, endpoint_select_field_r);
	assign issue_w = (st_r == UIR_ACC) && (cnt_r == 8'h00);

	// access sequencer: counts the controller access time, then commits or captures
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= UIR_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (st_r)
				UIR_IDLE: begin
					if (start_rd || start_wr) begin
						st_r <= UIR_ACC;
						cnt_r <= 8'(ACCESS_CYC - 1);
					end
				end
				UIR_ACC: begin
					if (cnt_r != 8'h00) begin
						cnt_r <= cnt_r - 8'h01;
					end else if (op_wr_r) begin
						st_r <= UIR_IDLE; // busy held to here
					end else begin
						st_r <= UIR_CAPT;
					end
				end
				UIR_CAPT: st_r <= UIR_IDLE;
				default: st_r <= UIR_IDLE;
			endcase
		end
	end

	// operation latched at start so later bus activity cannot disturb it
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			op_wr_r <= 1'b0;
			op_addr_r <= 6'h00;
			dec_r <= '0;
			wbyte_r <= `UIR_RESET_DATA;
		end else if (start_rd || start_wr) begin
			op_wr_r <= start_wr;
			op_addr_r <= op_addr_nxt;
			dec_r <= dec_nxt;
			if (start_wr) begin
				wbyte_r <= i_sfr_wdata;
			end
		end
	end

	// address/control register; ignored while busy so the target stays put
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			// fields come from the register reset value, cut to their own width
			auto_r <= 1'(`UIR_RESET_CTRL >> `UIR_AUTO_BIT);
			taddr_r <= 6'(`UIR_RESET_CTRL);
		end else if (wr_ctrl && idle_w) begin
			auto_r <= i_sfr_wdata[`UIR_AUTO_BIT];
			taddr_r <= i_sfr_wdata[`UIR_ADDR_MSB:0];
		end
	end

	// endpoint select lives in this block since it steers the decode
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			endpoint_select_field_r <= `UIR_RESET_ENDPOINT_SELECT_FIELD;
		end else if (issue_w && op_wr_r && dec_r.kind == UIR_K_INDEX) begin
			endpoint_select_field_r <= wbyte_r[3:0];
		end
	end

	// store access and fifo strobes on the last access cycle
	assign m.we = issue_w && op_wr_r && (dec_r.kind == UIR_K_MEM);
	assign m.re = issue_w && !op_wr_r && (dec_r.kind == UIR_K_MEM);
	assign m.addr = dec_r.slot;
	assign m.wdata = wbyte_r;
	assign o_fifo_wr_stb = issue_w && op_wr_r && (dec_r.kind == UIR_K_FIFO);
	assign o_fifo_rd_stb = issue_w && !op_wr_r && (dec_r.kind == UIR_K_FIFO);

	// fifo side data registered; the fifo answers one cycle after its pop
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fifo_ep <= 2'h0;
			o_fifo_wdata <= 8'h00;
		end else if (start_rd || start_wr) begin
			o_fifo_ep <= dec_nxt.slot[1:0];
			o_fifo_wdata <= i_sfr_wdata;
		end
	end

	// fetched byte captured as busy drops, so valid data and busy 0 coincide
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			data_r <= `UIR_RESET_DATA;
		end else if (st_r == UIR_CAPT) begin
			case (dec_r.kind)
				UIR_K_MEM: data_r <= m.rdata;
				UIR_K_FIFO: data_r <= i_fifo_rdata;
				UIR_K_FRAME_LO: data_r <= i_frame_num[7:0];
				UIR_K_FRAME_HI: data_r <= {5'h00, i_frame_num[10:8]};
				UIR_K_INDEX: data_r <= {4'h0, endpoint_select_field_r};
				default: data_r <= 8'h00;
			endcase
		end
	end

	// sfr read data registered; other addresses leave it unchanged
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_sfr_rdata <= 8'h00;
		end else if (rd_ctrl) begin
			o_sfr_rdata <= {busy_w, auto_r, taddr_r};
		end else if (rd_data) begin
			o_sfr_rdata <= data_r;
		end
	end

	// all checks sleep during reset, so an access cut by reset leaves no false failure
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_read_done;
		(st_r == UIR_CAPT) ##1 !busy_w;
	endsequence

	sequence s_write_done;
		m.we ##1 !busy_w;
	endsequence

	// a fifo pop is always followed by the capture cycle
	sequence s_fifo_pop;
		o_fifo_rd_stb ##1 (st_r == UIR_CAPT);
	endsequence

	// busy flag and the causes of an access
	a_busy_read: assert property (rd_ctrl |=> o_sfr_rdata[7] == $past(busy_w))
		else $error("busy bit read back wrong");
	a_kick_busy: assert property (start_rd |-> ##RD_LAT busy_w ##1 !busy_w)
		else $error("read did not last the access time");
	a_auto_kick: assert property (rd_data && auto_r && idle_w |=> busy_w && !op_wr_r
		&& op_addr_r == $past(taddr_r))
		else $error("auto read did not restart on the same address");
	a_addr_hold: assert property (busy_w |=> $stable(taddr_r) && $stable(auto_r))
		else $error("control register changed during an access");
	a_no_spont: assert property ($rose(busy_w) && !op_wr_r |-> $past(start_rd))
		else $error("read began without a cause");
	a_idle_quiet: assert property (idle_w |-> !m.re && !m.we && !o_fifo_rd_stb && !o_fifo_wr_stb)
		else $error("store or fifo touched while idle");

	// data register contents and write busy timing
	a_data_valid: assert property ((dec_r.kind == UIR_K_MEM) ##0 s_read_done
		|-> data_r == $past(m.rdata))
		else $error("data register not loaded from the store");
	a_data_kept: assert property (busy_w && op_wr_r |=> $stable(data_r))
		else $error("data register changed during a write");
	a_fifo_capture: assert property (s_fifo_pop |=> data_r == $past(i_fifo_rdata))
		else $error("fifo byte not captured");
	a_write_hold: assert property (start_wr && dec_nxt.kind == UIR_K_MEM
		|=> busy_w [*1] ##(ACCESS_CYC - 1) s_write_done)
		else $error("write released busy at the wrong time");

	// indirect map
	a_irq_map: assert property (busy_w && op_addr_r == `UIR_IX_CMN_IRQ
		|-> dec_r.kind == UIR_K_MEM && dec_r.slot == 7'h06)
		else $error("common flag register decoded wrong");
	a_ie_map: assert property (busy_w && op_addr_r == `UIR_IX_OUT_IE
		|-> dec_r.kind == UIR_K_MEM && dec_r.slot == 7'h09)
		else $error("out enable register decoded wrong");
	a_frame_hi: assert property ((st_r == UIR_CAPT) && dec_r.kind == UIR_K_FRAME_HI
		|=> data_r == {5'h00, $past(i_frame_num[10:8])})
		else $error("frame high byte wrong");
	a_fifo_route: assert property (o_fifo_rd_stb || o_fifo_wr_stb
		|-> op_addr_r[5:2] == `UIR_IX_FIFO_BASE && o_fifo_ep == op_addr_r[1:0])
		else $error("fifo access routed to the wrong endpoint");
	a_idx_bank: assert property ($rose(busy_w) && op_addr_r == `UIR_IX_EP0_CSR && endpoint_select_field_r < 4'h4
		|-> dec_r.slot == {1'b1, endpoint_select_field_r[1:0], 4'h1})
		else $error("indexed register bank wrong");
	a_ep_reserved: assert property ($rose(busy_w) && op_addr_r == `UIR_IX_OUT_CSR_LO && endpoint_select_field_r > 4'h3
		|-> dec_r.kind == UIR_K_NONE)
		else $error("reserved endpoint reached a register");
	a_index_upper: assert property ((st_r == UIR_CAPT) && dec_r.kind == UIR_K_INDEX
		|=> data_r[7:4] == 4'h0 && data_r[3:0] == $past(endpoint_select_field_r))
		else $error("index register read back wrong");
	a_endpoint_select_field_load: assert property (issue_w && op_wr_r && dec_r.kind == UIR_K_INDEX
		|=> endpoint_select_field_r == $past(wbyte_r[3:0]))
		else $error("endpoint select not loaded");
endmodule

// ### tb/uir_fifo_model.sv
// endpoint fifo stand-in on the far side of the port
`timescale 1ns/1ps
module uir_fifo_model (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_rd_stb,
	input wire logic i_wr_stb,
	input wire logic [1:0] i_ep,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic [7:0] o_last_wdata,
	output logic [1:0] o_last_ep
);
	logic [3:0] pop_cnt_r [4];

	// popped byte is {ep, 00, count}; between pops the bus flips so stale data never passes
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
			pop_cnt_r <= '{4'h0, 4'h0, 4'h0, 4'h0};
		end else if (i_rd_stb) begin
			o_rdata <= {i_ep, 2'b00, pop_cnt_r[i_ep]};
			pop_cnt_r[i_ep] <= pop_cnt_r[i_ep] + 4'h1;
		end else begin
			o_rdata <= ~o_rdata;
		end
	end

	// keep the last pushed byte for the bench to inspect
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_last_wdata <= 8'h00;
			o_last_ep <= 2'b00;
		end else if (i_wr_stb) begin
			o_last_wdata <= i_wdata;
			o_last_ep <= i_ep;
		end
	end
endmodule

// ### tb/tb_usb_indirect_register_port.sv
// self-checking bench for the indirect usb register port
`timescale 1ns/1ps
`include "uir_defines.svh"
module tb_usb_indirect_register_port import uir_pkg::*;;
	localparam int ACC = 2;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
	logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, o_fifo_wdata, fifo_rdata, last_wd;
	logic [10:0] i_frame_num = 11'h5a3;
	logic o_fifo_rd_stb, o_fifo_wr_stb;
	logic [1:0] o_fifo_ep, last_ep;
	logic [7:0] v;
	int miscompares = 0, cmp_count = 0;
	logic [5:0] mem_map [10] = '{6'h02, 6'h04, 6'h06, 6'h07, 6'h09, 6'h0b, 6'h00, 6'h01, 6'h0f, 6'h1e};
	logic [5:0] idx_map [6] = '{6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17};

	uir_port #(.ACCESS_CYC(ACC)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
		.i_frame_num(i_frame_num), .o_fifo_rd_stb(o_fifo_rd_stb), .o_fifo_wr_stb(o_fifo_wr_stb),
		.o_fifo_ep(o_fifo_ep), .o_fifo_wdata(o_fifo_wdata), .i_fifo_rdata(fifo_rdata));
	uir_fifo_model fifo (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd_stb(o_fifo_rd_stb),
		.i_wr_stb(o_fifo_wr_stb), .i_ep(o_fifo_ep), .i_wdata(o_fifo_wdata), .o_rdata(fifo_rdata),
		.o_last_wdata(last_wd), .o_last_ep(last_ep));

	// usb clock runs free for the whole run, so every access is legal
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// one-cycle strobes, changed only just after a rising edge
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_wr <= 1'b1;
		@(posedge i_clk);
		i_sfr_wr <= 1'b0;
	endtask

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_sfr_addr <= a;
		i_sfr_rd <= 1'b1;
		@(posedge i_clk);
		i_sfr_rd <= 1'b0;
		@(negedge i_clk);
		d = o_sfr_rdata;
	endtask

	// poll busy low under a bound, since writes during busy are dropped
	task automatic wait_idle();
		logic [7:0] c;
		for (int i = 0; i < 40; i++) begin
			sfr_rd(`UIR_SFR_CTRL, c);
			if (c[7] === 1'b0) return;
		end
		chk("busy clear", c, {1'b0, c[6:0]});
	endtask

	task automatic ind_wr(input logic [5:0] a, input logic [7:0] d);
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, {2'b00, a});
		sfr_wr(`UIR_SFR_DATA, d);
	endtask

	task automatic ind_rd(input logic [5:0] a, output logic [7:0] d);
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, {2'b10, a});
		wait_idle();
		sfr_rd(`UIR_SFR_DATA, d);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// generous bound: the sequence needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("ctrl reset", v, 8'h00);
		sfr_rd(`UIR_SFR_DATA, v);
		chk("data reset", v, 8'h00);
		$display("test reset done");
		// busy shows at once and clears with address kept
		sfr_wr(`UIR_SFR_CTRL, 8'h8e);
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("busy set", v, 8'h8e);
		wait_idle();
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("busy clear", v, 8'h0e);
		$display("test busy done");
		// write all common locations first so aliasing shows on read back
		foreach (mem_map[i]) ind_wr(mem_map[i], {2'b11, mem_map[i]});
		foreach (mem_map[i]) begin
			ind_rd(mem_map[i], v);
			chk("common reg", v, {2'b11, mem_map[i]});
		end
		$display("test common map done");
		for (int ep = 0; ep < 4; ep++) begin
			ind_wr(6'h0e, 8'(ep));
			foreach (idx_map[j]) ind_wr(idx_map[j], 8'(ep * 16 + j + 1));
		end
		for (int ep = 0; ep < 4; ep++) begin
			ind_wr(6'h0e, 8'(ep));
			ind_rd(6'h0e, v);
			chk("index", v, 8'(ep));
			foreach (idx_map[j]) begin
				ind_rd(idx_map[j], v);
				chk("indexed reg", v, 8'(ep * 16 + j + 1));
			end
		end
		// upper index bits are written but must read back as zero
		ind_wr(6'h0e, 8'hf5);
		ind_rd(6'h0e, v);
		chk("index upper", v, 8'h05);
		ind_rd(6'h14, v);
		chk("reserved ep", v, 8'h00);
		ind_rd(6'h03, v);
		chk("unmapped", v, 8'h00);
		$display("test indexed map done");
		ind_rd(6'h0c, v);
		chk("frame low", v, 8'ha3);
		ind_rd(6'h0d, v);
		chk("frame high", v, 8'h05);
		ind_wr(6'h0c, 8'hff);
		ind_rd(6'h0c, v);
		chk("frame read only", v, 8'ha3);
		$display("test frame done");
		// a control write while busy is dropped, so the first address stays
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, 8'h8c);
		sfr_wr(`UIR_SFR_CTRL, 8'h0d);
		wait_idle();
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("write while busy", v, 8'h0c);
		sfr_rd(`UIR_SFR_DATA, v);
		chk("busy read data", v, 8'ha3);
		$display("test busy drop done");
		// auto-read drains the endpoint 1 fifo
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, 8'he1);
		wait_idle();
		sfr_rd(`UIR_SFR_DATA, v);
		chk("auto byte 0", v, 8'h40);
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("auto rearm", v, 8'he1);
		wait_idle();
		sfr_rd(`UIR_SFR_DATA, v);
		chk("auto byte 1", v, 8'h41);
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, 8'h21);
		sfr_rd(`UIR_SFR_DATA, v);
		chk("manual byte", v, 8'h42);
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("no rearm", v, 8'h21);
		$display("test auto read done");
		ind_wr(6'h22, 8'h9d);
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("write busy", v, 8'ha2);
		wait_idle();
		chk("fifo push data", last_wd, 8'h9d);
		chk("fifo push ep", {6'h00, last_ep}, 8'h02);
		$display("test fifo write done");
		// reset in mid-access: busy, auto flag, address, data and index return to zero
		wait_idle();
		sfr_wr(`UIR_SFR_CTRL, 8'hce);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		sfr_rd(`UIR_SFR_CTRL, v);
		chk("ctrl mid reset", v, 8'h00);
		sfr_rd(`UIR_SFR_DATA, v);
		chk("data mid reset", v, 8'h00);
		ind_rd(6'h0e, v);
		chk("index mid reset", v, 8'h00);
		$display("test mid reset done");
		tally_and_finish();
	end
endmodule
